// file: rtl/bgc_defs.svh
`ifndef BGC_DEFS_SVH
`define BGC_DEFS_SVH

// register byte addresses on the apb side
`define GC_ADDR_CTRL        12'h000
`define GC_ADDR_CLKMASK     12'h004
`define GC_ADDR_STATUS      12'h008
`define GC_ADDR_DEVCAP      12'h094

// control register field positions
`define GC_ACTION_HI        22
`define GC_ACTION_LO        20
`define GC_LOOKAHEAD_BIT    19
`define GC_STANDBY_HI       18
`define GC_STANDBY_LO       16
`define GC_DEEP_IDLE_HI     15
`define GC_DEEP_IDLE_LO     13

// device capabilities mirror positions
`define CAP_STANDBY_HI      8
`define CAP_STANDBY_LO      6
`define CAP_DEEP_IDLE_HI    11
`define CAP_DEEP_IDLE_LO    9

// reset values
`define GC_STANDBY_RST      3'h0
`define GC_DEEP_IDLE_RST    3'h0
`define GC_LOOKAHEAD_RST    1'b0
`define GC_ACTION_FIXED     3'h0
`define GC_CLKMASK_RST      8'h00

// slot power action codes
`define ACT_IGNORE          3'h0
`define ACT_PIN             3'h1
`define ACT_CLK_OFF         3'h2
`define ACT_CLK_OFF_PIN     3'h3
`define ACT_UR              3'h4

// status register field positions
`define ST_PIN_BIT          0
`define ST_CLK_LO           8
`define ST_URCNT_LO         16

`endif

// file: rtl/bgc_pkg.sv
package bgc_pkg;

  // one apb request as seen in the access phase
  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_t;

  // software-visible fields of the general control register
  typedef struct packed {
    logic       read_lookahead_off;
    logic [2:0] standby_exit_limit;
    logic [2:0] deep_idle_exit_limit;
  } gen_ctrl_t;

  // kinds of transaction offered to the ur check
  typedef enum logic [2:0] {
    TXN_MEM,
    TXN_IO,
    TXN_CFG0,
    TXN_CFG1,
    TXN_MSG_SLOT_PWR,
    TXN_MSG_OTHER
  } txn_kind_t;

  // apb answer sequencing
  typedef enum logic [1:0] {
    AP_IDLE,
    AP_WAIT,
    AP_DONE
  } apb_state_t;

endpackage

// file: rtl/exit_limit_decode.sv
`timescale 1ns/10ps
// turns a 3-bit exit latency code into its lower bound in ns
module exit_limit_decode
  import bgc_pkg::*;
#(
  parameter bit DEEP = 1'b0  // 0: standby table, 1: deep idle table
) (
  input  wire logic [2:0]  code,
  output logic      [16:0] floor_ns
);

  // lower bound of each band; code 7 means above the last bound
  always_comb begin
    floor_ns = 17'h0_0000;
    case ({DEEP, code})
      4'h1:    floor_ns = 17'd64;
      4'h2:    floor_ns = 17'd128;
      4'h3:    floor_ns = 17'd256;
      4'h4:    floor_ns = 17'd512;
      4'h5:    floor_ns = 17'd1000;
      4'h6:    floor_ns = 17'd2000;
      4'h7:    floor_ns = 17'd4000;
      4'h9:    floor_ns = 17'd1000;
      4'hA:    floor_ns = 17'd2000;
      4'hB:    floor_ns = 17'd4000;
      4'hC:    floor_ns = 17'd8000;
      4'hD:    floor_ns = 17'd16000;
      4'hE:    floor_ns = 17'd32000;
      4'hF:    floor_ns = 17'd64000;
      default: floor_ns = 17'h0_0000;
    endcase
  end

endmodule // exit_limit_decode

// file: rtl/fetch_span_calc.sv
`timescale 1ns/10ps
// number of dwords a burst read fetches from its start address
module fetch_span_calc
  import bgc_pkg::*;
#(
  parameter int LINE_DW = 8  // cache line length in dwords
) (
  input  wire logic       lookahead_off,
  input  wire logic [7:0] start_dw,
  output logic      [7:0] span_dw
);

  // offset of the start dword inside its cache line
  logic [7:0] line_pos;

  assign line_pos = start_dw % 8'(LINE_DW);

  // single dword when look-ahead is off, else up to the line boundary
  assign span_dw = lookahead_off ? 8'h01 : 8'(LINE_DW) - line_pos;

endmodule // fetch_span_calc

// file: rtl/bridge_general_control_fields.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "bgc_defs.svh"
module bridge_general_control_fields
  import bgc_pkg::*;
#(
  parameter int LINE_DW = 8  // cache line length in dwords
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic      [31:0] PRDATA,
  output logic             PSLVERR,
  input  wire logic        SLOT_POWER_SHORT,
  input  wire logic        TXN_VALID,
  input  wire logic [2:0]  TXN_KIND,
  input  wire logic        BURST_REQ,
  input  wire logic [7:0]  BURST_START_DW,
  output logic             POWER_OVERRIDE_PIN,
  output logic      [7:0]  SEC_CLK_OFF,
  output logic             TXN_DONE,
  output logic             TXN_UR,
  output logic             FETCH_VALID,
  output logic      [7:0]  FETCH_DWORDS,
  output logic      [16:0] STANDBY_LIMIT_NS,
  output logic      [16:0] DEEP_IDLE_LIMIT_NS
);

  // ---------------------------------------------------------------
  // apb request capture and decode
  // ---------------------------------------------------------------
  apb_req_t   req;            // bundled access-phase request
  apb_state_t ap_state;       // answer sequencer state
  apb_state_t next_ap_state;  // its next value

  assign req = '{addr: PADDR, write: PWRITE, wdata: PWDATA, strb: PSTRB};

  // address hits
  logic hit_ctrl;     // general control register
  logic hit_clkmask;  // secondary clock mask register
  logic hit_status;   // status register
  logic hit_devcap;   // device capabilities mirror
  logic hit_any;      // any mapped register

  assign hit_ctrl    = (req.addr == `GC_ADDR_CTRL);
  assign hit_clkmask = (req.addr == `GC_ADDR_CLKMASK);
  assign hit_status  = (req.addr == `GC_ADDR_STATUS);
  assign hit_devcap  = (req.addr == `GC_ADDR_DEVCAP);
  assign hit_any     = hit_ctrl | hit_clkmask | hit_status | hit_devcap;

  // access phase seen, and the edge where it completes
  logic in_access;  // psel and penable both high
  logic complete;   // pready high at this edge
  logic wr_commit;  // write takes effect now

  assign in_access = PSEL & PENABLE;
  assign complete  = in_access & PREADY;
  assign wr_commit = complete & req.write & hit_any;

  // answer sequencer: one wait cycle, then ready for one cycle
  always_comb begin
    next_ap_state = ap_state;
    case (ap_state)
      AP_IDLE: begin
        // access phase just started
        if (in_access) begin
          next_ap_state = AP_WAIT;
        end
      end
      AP_WAIT: begin
        // pready is being driven high this cycle
        next_ap_state = AP_DONE;
      end
      AP_DONE: begin
        // pready back low, wait for the next access
        next_ap_state = AP_IDLE;
      end
      default: begin
        next_ap_state = AP_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ap_state <= AP_IDLE;
    end else begin
      ap_state <= next_ap_state;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  gen_ctrl_t  ctrl;          // programmable fields
  gen_ctrl_t  next_ctrl;     // their next value
  logic [7:0] clk_mask;      // clocks chosen for gating
  logic [7:0] next_clk_mask; // its next value
  logic [2:0] slot_action;   // slot power action, hardwired

  // action field is a constant, so writes cannot reach it
  assign slot_action = `GC_ACTION_FIXED;

  // byte-lane merge of a control write; action bits dropped
  always_comb begin
    next_ctrl = ctrl;
    if (wr_commit && hit_ctrl) begin
      // byte 2 carries look-ahead and standby limit
      if (req.strb[2]) begin
        next_ctrl.read_lookahead_off = req.wdata[`GC_LOOKAHEAD_BIT];
        next_ctrl.standby_exit_limit =
          req.wdata[`GC_STANDBY_HI:`GC_STANDBY_LO];
      end
      // byte 1 carries the deep idle limit
      if (req.strb[1]) begin
        next_ctrl.deep_idle_exit_limit =
          req.wdata[`GC_DEEP_IDLE_HI:`GC_DEEP_IDLE_LO];
      end
    end
  end

  // clock mask write, low byte only
  assign next_clk_mask = (wr_commit && hit_clkmask && req.strb[0]) ?
                         req.wdata[7:0] : clk_mask;

  // register storage with documented reset codes
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl.read_lookahead_off   <= `GC_LOOKAHEAD_RST;
      ctrl.standby_exit_limit   <= `GC_STANDBY_RST;
      ctrl.deep_idle_exit_limit <= `GC_DEEP_IDLE_RST;
      clk_mask                  <= `GC_CLKMASK_RST;
    end else begin
      ctrl     <= next_ctrl;
      clk_mask <= next_clk_mask;
    end
  end

  // ---------------------------------------------------------------
  // read data views
  // ---------------------------------------------------------------
  logic [31:0] ctrl_view;    // general control as read
  logic [31:0] devcap_view;  // capability mirror as read
  logic [31:0] status_view;  // live status as read
  logic [31:0] mask_view;    // clock mask as read
  logic [31:0] rd_mux;       // selected read word
  logic [15:0] ur_count;     // ur answers given, wraps

  // control word; the action field always shows zero
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[`GC_ACTION_HI:`GC_ACTION_LO] = slot_action;
    ctrl_view[`GC_LOOKAHEAD_BIT] = ctrl.read_lookahead_off;
    ctrl_view[`GC_STANDBY_HI:`GC_STANDBY_LO] = ctrl.standby_exit_limit;
    ctrl_view[`GC_DEEP_IDLE_HI:`GC_DEEP_IDLE_LO] = ctrl.deep_idle_exit_limit;
  end

  // capability word tracks the programmed limits directly
  always_comb begin
    devcap_view = 32'h0000_0000;
    devcap_view[`CAP_STANDBY_HI:`CAP_STANDBY_LO] =
      ctrl.standby_exit_limit;
    devcap_view[`CAP_DEEP_IDLE_HI:`CAP_DEEP_IDLE_LO] =
      ctrl.deep_idle_exit_limit;
  end

  // status word: pin, gated clocks, ur count
  always_comb begin
    status_view = 32'h0000_0000;
    status_view[`ST_PIN_BIT] = POWER_OVERRIDE_PIN;
    status_view[`ST_CLK_LO +: 8] = SEC_CLK_OFF;
    status_view[`ST_URCNT_LO +: 16] = ur_count;
  end

  assign mask_view = {24'h00_0000, clk_mask};

  // read selection; unmapped reads give zero
  assign rd_mux = hit_ctrl    ? ctrl_view   :
                  hit_clkmask ? mask_view   :
                  hit_status  ? status_view :
                  hit_devcap  ? devcap_view : 32'h0000_0000;

  // answer flops: pready, read data, error for unmapped
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= (next_ap_state == AP_WAIT);
      PSLVERR <= (next_ap_state == AP_WAIT) & ~hit_any;
      // data held stable while pready is high
      if (next_ap_state == AP_WAIT) begin
        PRDATA <= req.write ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // slot power action handling
  // ---------------------------------------------------------------
  logic       pin_code;      // action asks for the pin
  logic       clk_code;      // action asks for clock gating
  logic       ur_code;       // action asks for ur answers
  logic       txn_exempt;    // config or slot power message
  logic       next_pin;      // next override pin level
  logic [7:0] next_clk_off;  // next gated clock set
  logic       next_ur;       // next ur answer

  // decode the action code
  assign pin_code = (slot_action == `ACT_PIN) |
                    (slot_action == `ACT_CLK_OFF_PIN);
  assign clk_code = (slot_action == `ACT_CLK_OFF) |
                    (slot_action == `ACT_CLK_OFF_PIN);
  assign ur_code  = (slot_action == `ACT_UR);

  // configuration type 0/1 and slot power messages pass
  assign txn_exempt = (TXN_KIND == 3'(TXN_CFG0)) |
                      (TXN_KIND == 3'(TXN_CFG1)) |
                      (TXN_KIND == 3'(TXN_MSG_SLOT_PWR));

  // every action applies only while slot power falls short
  assign next_pin     = pin_code & SLOT_POWER_SHORT;
  assign next_clk_off = (clk_code & SLOT_POWER_SHORT) ? clk_mask
                                                     : 8'h00;
  assign next_ur      = TXN_VALID & ur_code & SLOT_POWER_SHORT &
                        ~txn_exempt;

  // registered action outputs
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      POWER_OVERRIDE_PIN <= 1'b0;
      SEC_CLK_OFF        <= 8'h00;
      TXN_DONE           <= 1'b0;
      TXN_UR             <= 1'b0;
    end else begin
      POWER_OVERRIDE_PIN <= next_pin;
      SEC_CLK_OFF        <= next_clk_off;
      TXN_DONE           <= TXN_VALID;
      TXN_UR             <= next_ur;
    end
  end

  // count ur answers for software visibility
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ur_count <= 16'h0000;
    end else if (next_ur) begin
      ur_count <= ur_count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // memory read look-ahead
  // ---------------------------------------------------------------
  logic [7:0] span_dw;  // dwords to fetch for this burst

  // span follows the look-ahead control bit
  fetch_span_calc #(
    .LINE_DW (LINE_DW)
  ) u_span (
    .lookahead_off (ctrl.read_lookahead_off),
    .start_dw      (BURST_START_DW),
    .span_dw       (span_dw)
  );

  // fetch length reported one cycle after the burst request
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FETCH_VALID  <= 1'b0;
      FETCH_DWORDS <= 8'h00;
    end else begin
      FETCH_VALID <= BURST_REQ;
      if (BURST_REQ) begin
        FETCH_DWORDS <= span_dw;
      end
    end
  end

  // ---------------------------------------------------------------
  // exit latency interpretation
  // ---------------------------------------------------------------
  logic [16:0] standby_ns;    // standby band lower bound
  logic [16:0] deep_idle_ns;  // deep idle band lower bound

  // standby table: bounds from 64 ns, doubling, up to above 4 us
  exit_limit_decode #(
    .DEEP (1'b0)
  ) u_standby (
    .code     (ctrl.standby_exit_limit),
    .floor_ns (standby_ns)
  );

  // deep idle table: bounds from 1 us, doubling, up to above 64 us
  exit_limit_decode #(
    .DEEP (1'b1)
  ) u_deep_idle (
    .code     (ctrl.deep_idle_exit_limit),
    .floor_ns (deep_idle_ns)
  );

  // registered band bounds for the link power logic
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      STANDBY_LIMIT_NS   <= 17'h0_0000;
      DEEP_IDLE_LIMIT_NS <= 17'h0_0000;
    end else begin
      STANDBY_LIMIT_NS   <= standby_ns;
      DEEP_IDLE_LIMIT_NS <= deep_idle_ns;
    end
  end

endmodule // bridge_general_control_fields

// file: sim/bgc_asserts.sv
`timescale 1ns/10ps
// port-level checker for the general control block
module bgc_asserts
  import bgc_pkg::*;
#(
  parameter int LINE_DW = 8  // cache line length in dwords
) (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        TXN_VALID,
  input wire logic        TXN_DONE,
  input wire logic        TXN_UR,
  input wire logic        BURST_REQ,
  input wire logic [7:0]  BURST_START_DW,
  input wire logic        FETCH_VALID,
  input wire logic [7:0]  FETCH_DWORDS,
  input wire logic        POWER_OVERRIDE_PIN,
  input wire logic [7:0]  SEC_CLK_OFF,
  input wire logic [16:0] STANDBY_LIMIT_NS,
  input wire logic [16:0] DEEP_IDLE_LIMIT_NS
);
  // lower band bounds in ns per code
  localparam int st_ns[8] = '{0, 64, 128, 256, 512, 1000, 2000, 4000};
  localparam int dp_ns[8] = '{0, 1000, 2000, 4000, 8000, 16000, 32000, 64000};
  logic [2:0] sh_s;    // shadow of the standby limit
  logic [2:0] sh_d;    // shadow of the deep idle limit
  logic       sh_off;  // shadow of the look-ahead disable
  // a control write commits at the edge where the slave is ready
  wire wr_ctl = PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000;
  // shadow follows committed writes lane by lane
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sh_s   <= 3'h0;
      sh_d   <= 3'h0;
      sh_off <= 1'b0;
    end else if (wr_ctl) begin
      if (PSTRB[2]) begin
        sh_s   <= PWDATA[18:16];
        sh_off <= PWDATA[19];
      end
      if (PSTRB[1]) begin
        sh_d <= PWDATA[15:13];
      end
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_action_zero:
    assert property (PREADY && !PWRITE && PADDR == 12'h000 |-> PRDATA[22:20] == 3'h0)
      else $error("action field reads nonzero");
  a_devcap_mirror:
    assert property (PREADY && !PWRITE && PADDR == 12'h094
                     |-> PRDATA[8:6] == sh_s && PRDATA[11:9] == sh_d)
      else $error("capability mirror differs");
  a_limits_reset:
    assert property ($fell(RST) |-> STANDBY_LIMIT_NS == 17'h0_0000 && DEEP_IDLE_LIMIT_NS == 17'h0_0000)
      else $error("limits not zero after reset");
  a_standby_band:
    assert property (!$past(wr_ctl) |-> STANDBY_LIMIT_NS == 17'(st_ns[sh_s]))
      else $error("standby band wrong");
  a_deep_band:
    assert property (!$past(wr_ctl) |-> DEEP_IDLE_LIMIT_NS == 17'(dp_ns[sh_d]))
      else $error("deep idle band wrong");
  a_no_action:
    assert property (!POWER_OVERRIDE_PIN && SEC_CLK_OFF == 8'h00)
      else $error("power action taken");
  a_no_ur_reply:
    assert property (TXN_VALID |=> TXN_DONE && !TXN_UR)
      else $error("transaction refused or late");
  a_single_dword:
    assert property (BURST_REQ && sh_off |=> FETCH_VALID && FETCH_DWORDS == 8'h01)
      else $error("look-ahead off fetched more");
  a_line_fetch:
    assert property (BURST_REQ && !sh_off
                     |=> FETCH_VALID &&
                         FETCH_DWORDS == 8'(LINE_DW - $past(BURST_START_DW) % LINE_DW))
      else $error("line fetch length wrong");
endmodule // bgc_asserts

bind bridge_general_control_fields bgc_asserts #(.LINE_DW(LINE_DW)) i_bgc_asserts (.*);

// file: sim/far_side_model.sv
`timescale 1ns/10ps
// upstream traffic source for the transaction and burst ports
module far_side_model
  import bgc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       done,
  input  wire logic       ur,
  input  wire logic       fvalid,
  input  wire logic [7:0] fdw,
  output logic            txn_valid,
  output logic      [2:0] txn_kind,
  output logic            burst_req,
  output logic      [7:0] start_dw,
  output logic            slot_short
);
  // idle values; slot power kept short to provoke any action
  initial begin
    txn_valid  = 1'b0;
    txn_kind   = 3'h0;
    burst_req  = 1'b0;
    start_dw   = 8'h00;
    slot_short = 1'b1;
  end
  // one transaction; kind is scrambled once released
  task automatic txn(input logic [2:0] k, output logic d, output logic u);
    @(posedge clk);
    txn_valid <= 1'b1;
    txn_kind  <= k;
    @(posedge clk);
    txn_valid <= 1'b0;
    txn_kind  <= ~k;
    @(posedge clk);
    d = done;
    u = ur;
  endtask
  // one burst read request from a dword address
  task automatic burst(input logic [7:0] s, output logic v, output logic [7:0] n);
    @(posedge clk);
    burst_req <= 1'b1;
    start_dw  <= s;
    @(posedge clk);
    burst_req <= 1'b0;
    start_dw  <= ~s;
    @(posedge clk);
    v = fvalid;
    n = fdw;
  endtask
endmodule // far_side_model

// file: sim/testbench.sv
`timescale 1ns/10ps
// drives the control block over apb and its upstream ports
module testbench import bgc_pkg::*;;
  localparam int st_ns[8] = '{0, 64, 128, 256, 512, 1000, 2000, 4000};
  localparam int dp_ns[8] = '{0, 1000, 2000, 4000, 8000, 16000, 32000, 64000};
  logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [3:0]  PSTRB;
  logic SLOT_POWER_SHORT, TXN_VALID, BURST_REQ, POWER_OVERRIDE_PIN;
  logic TXN_DONE, TXN_UR, FETCH_VALID, e, d, u, v;
  logic [2:0]  TXN_KIND;
  logic [7:0]  BURST_START_DW, SEC_CLK_OFF, FETCH_DWORDS, nd;
  logic [16:0] STANDBY_LIMIT_NS, DEEP_IDLE_LIMIT_NS;
  int miscompares = 0;
  int n_tests = 0;
  bridge_general_control_fields #(.LINE_DW(8)) i_bridge_general_control_fields (.*);
  far_side_model i_far_side_model (.clk(MCLK), .done(TXN_DONE), .ur(TXN_UR),
    .fvalid(FETCH_VALID), .fdw(FETCH_DWORDS), .txn_valid(TXN_VALID),
    .txn_kind(TXN_KIND), .burst_req(BURST_REQ), .start_dw(BURST_START_DW),
    .slot_short(SLOT_POWER_SHORT));
  // 200 MHz clock
  initial MCLK = 1'b0;
  always #2.5 MCLK = ~MCLK;
  // counts and verdict, then stop
  task summarize;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // compare one word
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one apb transfer: setup, access until ready, then release
  task apb(input logic [11:0] a, input logic w, input logic [31:0] dt,
           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= dt;
    PSTRB   <= s;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("Error at %0t: no pready within 20 cycles", $time);
      miscompares++;
      summarize;
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // main sequence
  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    apb(12'h000, 1'b0, 32'h0000_0000, 4'h0);
    check(r & 32'h007F_E000, 32'h0000_0000);
    apb(12'h094, 1'b0, 32'h0000_0000, 4'h0);
    check(r & 32'h0000_0FC0, 32'h0000_0000);
    $display("test reset values done");
    // each code once per limit, paired as i and 7 - i, with writes aimed at the fixed action field
    for (int i = 0; i < 8; i++) begin
      apb(12'h000, 1'b1, {9'h0, 3'h7, i[0], i[2:0], 3'(7 - i), 13'h0}, 4'hF);
      apb(12'h000, 1'b0, 32'h0000_0000, 4'h0);
      check(r & 32'h007F_E000, {9'h0, 3'h0, i[0], i[2:0], 3'(7 - i), 13'h0});
      apb(12'h094, 1'b0, 32'h0000_0000, 4'h0);
      check(r & 32'h0000_0FC0, {20'h0, 3'(7 - i), i[2:0], 6'h0});
      check(32'(STANDBY_LIMIT_NS), st_ns[i]);
      check(32'(DEEP_IDLE_LIMIT_NS), dp_ns[7 - i]);
    end
    // only byte lane one written
    apb(12'h000, 1'b1, 32'h0072_A000, 4'h2);
    apb(12'h000, 1'b0, 32'h0000_0000, 4'h0);
    check(r & 32'h007F_E000, 32'h000F_A000);
    $display("test limit codes done");
    i_far_side_model.burst(8'h03, v, nd);
    check({23'h0, v, nd}, {23'h0, 1'b1, 8'h01});
    apb(12'h000, 1'b1, 32'h0000_0000, 4'hF);
    for (int s = 7; s < 10; s++) begin
      i_far_side_model.burst(8'(s), v, nd);
      check({23'h0, v, nd}, {23'h0, 1'b1, 8'(8 - s % 8)});
    end
    $display("test burst fetch done");
    apb(12'h004, 1'b1, 32'h0000_00FF, 4'hF);
    for (int k = 0; k < 6; k++) begin
      i_far_side_model.txn(3'(k), d, u);
      check({30'h0, d, u}, 32'h0000_0002);
      check({23'h0, POWER_OVERRIDE_PIN, SEC_CLK_OFF}, 32'h0000_0000);
    end
    apb(12'h008, 1'b0, 32'h0000_0000, 4'h0);
    check(r, 32'h0000_0000);
    $display("test slot power action done");
    apb(12'h010, 1'b0, 32'h0000_0000, 4'h0);
    check({r[30:0], e}, 32'h0000_0001);
    $display("test unmapped access done");
    summarize;
  end
endmodule // testbench
